// *** bench/regulator_loop_seq_track_cfg_test.sv ***
/*
  Self-checking bench: register table loop, dead time, sequencing, reset.
  Assumes the host model and the group bus events share the clock.
*/
`timescale 1ns/100ps
module regulator_loop_seq_track_cfg_test;
  typedef struct {logic [7:0] c; int n; logic [47:0] v, e;} rlstc_row_s;
  logic clock = 1'h0, rst = 1'h1, en = 1'h0, ev_v = 1'h0, ev_pg = 1'h0;
  logic [4:0] ev_id = 5'h00;
  logic signed [7:0] ahl = 8'sh00, alh = 8'sh00, dhl, dlh;
  logic rail_on, boost, f_en, f_half, f_lim, sda_oe;
  logic [15:0] gain;
  logic [7:0] resid;
  logic [47:0] rv;
  wire scl, sda;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  rlstc_row_s rows[6] = '{'{8'hde, 2, 48'h7f7f, 48'h7f7f},
    '{8'hdf, 5, 48'hff12345604, 48'h0112345604},
    '{8'hdf, 5, 48'h0000000003, 48'h0112345604},
    '{8'he0, 2, 48'hffff, 48'h9f9f}, '{8'he1, 1, 48'hff, 48'h86},
    '{8'he1, 1, 48'h84, 48'h84}};
  always #4 clock = ~clock;
  rlstc_host u_host (.clock(clock), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  rlstc_top u_dut (.clock(clock), .rst(rst), .pm_scl_i(scl), .pm_sda_i(sda),
    .pm_sda_o(), .pm_sda_oe(sda_oe), .enable_req(en), .gcb_evt_valid(ev_v),
    .gcb_evt_pg(ev_pg), .gcb_evt_id(ev_id), .off_delay_cyc(16'h0004),
    .dt_adapt_hl(ahl), .dt_adapt_lh(alh), .rail_on(rail_on),
    .dt_hl_ns(dhl), .dt_lh_ns(dlh), .loop_response_boost_en(boost),
    .loop_gain(gain), .loop_residual(resid), .follow_en(f_en),
    .follow_half(f_half), .follow_limit_pin(f_lim));
  task automatic cy(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic ev(input logic pg, input logic [4:0] id);
    @(posedge clock);
    ev_v <= 1'h1;
    ev_pg <= pg;
    ev_id <= id;
    @(posedge clock);
    ev_v <= 1'h0;
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    cy(3);
    rst <= 1'h0;
    cy(3);
    foreach (rows[i]) begin
      u_host.wr(rows[i].c, rows[i].v, rows[i].n);
      u_host.rd(rows[i].c, rows[i].n, rv);
      chk(rv, rows[i].e);
    end
    chk({boost, resid, gain}, {1'h1, 8'h12, 16'h3456});
    chk({f_en, f_half, f_lim}, 3'h6);
    // Value write right before mode write loads the adaptive maximum
    u_host.wr(8'hdd, 48'h1e14, 2);
    u_host.wr(8'hde, 48'h8080, 2);
    cy(2);
    chk({dhl, dlh}, 16'h1e14);
    ahl <= 8'sh64;
    u_host.wr(8'hde, 48'h0202, 2);
    cy(2);
    chk({dhl, dlh}, 16'h1e04);
    // Minimum codes beyond the range clamp; minimum beats the maximum
    u_host.wr(8'hde, 48'h1e42, 2);
    cy(2);
    chk({dhl, dlh}, 16'h3800);
    u_host.wr(8'he0, 48'h8581, 2);
    en <= 1'h1;
    cy(20);
    chk(rail_on, 1'h0);
    ev(1'h1, 5'h06);
    cy(5);
    chk(rail_on, 1'h0);
    ev(1'h1, 5'h05);
    cy(3);
    chk(rail_on, 1'h1);
    en <= 1'h0;
    cy(20);
    chk(rail_on, 1'h1);
    ev(1'h0, 5'h01);
    cy(4);
    chk(rail_on, 1'h1);
    cy(6);
    chk(rail_on, 1'h0);
    u_host.wr(8'he0, 48'h0000, 2);
    en <= 1'h1;
    cy(3);
    chk(rail_on, 1'h1);
    // Reset in mid-run clears the command registers and the rail
    rst <= 1'h1;
    en <= 1'h0;
    ahl <= 8'sh00;
    cy(3);
    rst <= 1'h0;
    cy(3);
    chk({rail_on, boost, f_en, dhl, dlh}, 19'h0);
    u_host.rd(8'hdf, 5, rv);
    chk(rv, 48'h04);
    end_of_test();
  end
endmodule

// *** bench/rlstc_host.sv ***
/*
  PMBus host model bit-banging an open-drain data wire with pull-up.
  Assumes target address 0x40 and a clock far faster than SCL.
*/
`timescale 1ns/100ps
module rlstc_host (
  input  wire logic clock,    // System clock
  input  wire logic dev_pull, // Target pulls data low
  output logic      scl,      // PMBus clock
  output wire logic sda       // Data wire level
);
  logic hp;
  assign sda = !(hp | dev_pull);
  initial begin
    scl = 1'h1;
    hp  = 1'h0;
  end
  task automatic hc();
    repeat (8) @(posedge clock);
  endtask
  // Start or repeated start, ends with SCL low
  task automatic st();
    hp <= 1'h0;
    hc();
    scl <= 1'h1;
    hc();
    hp <= 1'h1;
    hc();
    scl <= 1'h0;
    hc();
  endtask
  task automatic sp();
    hp <= 1'h1;
    hc();
    scl <= 1'h1;
    hc();
    hp <= 1'h0;
    hc();
  endtask
  // Eight data bits and the acknowledge bit, MSB first
  task automatic xb(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      hp <= !d[i];
      hc();
      scl <= 1'h1;
      hc();
      q[i] = sda;
      scl <= 1'h0;
      hc();
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [47:0] v, input int n);
    logic [8:0] q;
    st();
    xb({8'h80, 1'h1}, q);
    xb({c, 1'h1}, q);
    for (int i = 0; i < n; i++) xb({v[8*i +: 8], 1'h1}, q);
    sp();
  endtask
  task automatic rd(input logic [7:0] c, input int n, output logic [47:0] v);
    logic [8:0] q;
    v = '0;
    st();
    xb({8'h80, 1'h1}, q);
    xb({c, 1'h1}, q);
    st();
    xb({8'h81, 1'h1}, q);
    for (int i = 0; i < n; i++) begin
      xb({8'hff, 1'(i == n - 1)}, q);
      v[8*i +: 8] = q[8:1];
    end
    sp();
  endtask
endmodule

// *** hdl/rlstc_dt_chan.sv ***
/*
  One dead-time channel: holds the adaptive maximum, clamps the
  adaptive request between minimum and maximum, or passes the fixed
  value when frozen. Assumes all inputs are on the same clock.
*/
`timescale 1ns/100ps
`include "rlstc_regs.svh"

module rlstc_dt_chan
  import rlstc_pkg::*;
(
  input  wire logic              clock,      // System clock
  input  wire logic              rst,        // Async reset, high
  input  wire logic              fixed_mode, // 1 freezes dead time
  input  wire logic        [6:0] min_code,   // Minimum, 2 ns steps
  input  wire logic signed [7:0] fixed_ns,   // Dead-time value, ns
  input  wire logic              max_load,   // Take fixed_ns as maximum
  input  wire logic signed [7:0] adapt_ns,   // Adaptive request, ns
  output logic signed      [7:0] dt_ns_q     // Dead time in use, ns
);

  logic signed [7:0] max_q;
  logic signed [6:0] min_c;
  logic signed [7:0] min_ns;
  logic signed [7:0] dt_d;

  always_comb begin
    min_c = min_code;
    if (min_c < `RLSTC_DT_MIN_LO) begin
      min_c = `RLSTC_DT_MIN_LO;
    end else if (min_c > `RLSTC_DT_MIN_HI) begin
      min_c = `RLSTC_DT_MIN_HI;
    end
    min_ns = {min_c, 1'b0};
    if (fixed_mode) begin
      dt_d = fixed_ns;
    end else if (adapt_ns < min_ns || max_q < min_ns) begin
      // Minimum wins over a lower adaptive maximum
      dt_d = min_ns;
    end else if (adapt_ns > max_q) begin
      dt_d = max_q;
    end else begin
      dt_d = adapt_ns;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      max_q <= `RLSTC_DT_MAX_RST;
    end else if (max_load) begin
      max_q <= fixed_ns;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dt_ns_q <= 8'sh00;
    end else begin
      dt_ns_q <= dt_d;
    end
  end

endmodule

// *** hdl/rlstc_pkg.sv ***
/*
  Types shared by the configuration block and its submodules.
  Assumes rlstc_regs.svh is on the include path.
*/
`include "rlstc_regs.svh"

package rlstc_pkg;

  typedef enum logic [2:0] {PM_IDLE, PM_RX, PM_RACK, PM_TX, PM_TACK} rlstc_pm_e;
  typedef enum logic [1:0] {SEQ_OFF, SEQ_WAIT_PRE, SEQ_ON, SEQ_OFF_DLY}
    rlstc_seq_e;

  function automatic logic rlstc_cmd_known(input logic [7:0] c);
    return c inside {`RLSTC_CMD_DT_VALUE, `RLSTC_CMD_GAP, `RLSTC_CMD_LOOP,
                     `RLSTC_CMD_ORDER, `RLSTC_CMD_FOLLOW};
  endfunction

endpackage

// *** hdl/rlstc_pmbus_slave.sv ***
/*
  Byte engine of the PMBus target: start/stop detection, address
  match, command acknowledge, write strobes and read byte fetch.
  Assumes SCL is far slower than the clock; no clock stretching.
*/
`timescale 1ns/100ps
`include "rlstc_regs.svh"

module rlstc_pmbus_slave
  import rlstc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40
)(
  input  wire logic       clock,    // System clock
  input  wire logic       rst,      // Async reset, high
  input  wire logic       scl_i,    // PMBus clock pin
  input  wire logic       sda_i,    // PMBus data pin level
  output logic            sda_oe,   // Pull data low when high
  output logic            wr_stb,   // Byte received and acked
  output logic      [7:0] wr_data,  // Received byte
  output logic      [2:0] wr_idx,   // 0 is command, then data
  output logic      [2:0] rd_idx,   // Index of byte being fetched
  output logic            stop_stb, // Stop seen
  input  wire logic [7:0] rd_byte   // Byte to send for rd_idx
);

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       ack_ok;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic       first_q;
  logic       rw_q;
  rlstc_pm_e  state_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_c   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  assign ack_ok   = first_q ? (sh_q[7:1] == DEV_ADDR)
                            : ((wr_idx != 3'h0) || rlstc_cmd_known(sh_q));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q  <= PM_IDLE;
      sda_oe   <= 1'b0;
      wr_stb   <= 1'b0;
      wr_data  <= 8'h00;
      wr_idx   <= 3'h0;
      rd_idx   <= 3'h0;
      stop_stb <= 1'b0;
      sh_q     <= 8'h00;
      cnt_q    <= 4'h0;
      first_q  <= 1'b0;
      rw_q     <= 1'b0;
    end else begin
      wr_stb   <= 1'b0;
      stop_stb <= 1'b0;
      if (start_c) begin
        state_q <= PM_RX;
        sda_oe  <= 1'b0;
        cnt_q   <= 4'h0;
        first_q <= 1'b1;
        wr_idx  <= 3'h0;
        rd_idx  <= 3'h0;
      end else if (stop_c) begin
        state_q  <= PM_IDLE;
        sda_oe   <= 1'b0;
        stop_stb <= 1'b1;
      end else begin
        unique case (state_q)
          PM_IDLE: begin
          end
          PM_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_s[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `RLSTC_BIT_LAST) begin
              if (first_q) begin
                rw_q <= sh_q[0];
              end else begin
                wr_stb  <= ack_ok;
                wr_data <= sh_q;
              end
              sda_oe  <= ack_ok;
              state_q <= ack_ok ? PM_RACK : PM_IDLE;
            end
          end
          PM_RACK: begin
            if (scl_fall) begin
              first_q <= 1'b0;
              if (first_q && rw_q) begin
                state_q <= PM_TX;
                sda_oe  <= ~rd_byte[7];
                sh_q    <= {rd_byte[6:0], 1'b0};
                cnt_q   <= 4'h1;
                rd_idx  <= rd_idx + 3'h1;
              end else begin
                state_q <= PM_RX;
                sda_oe  <= 1'b0;
                cnt_q   <= 4'h0;
                if (!first_q && wr_idx != 3'h7) begin
                  wr_idx <= wr_idx + 3'h1;
                end
              end
            end
          end
          PM_TX: begin
            if (scl_fall) begin
              if (cnt_q == `RLSTC_BIT_LAST) begin
                sda_oe  <= 1'b0;
                state_q <= PM_TACK;
              end else begin
                sda_oe <= ~sh_q[7];
                sh_q   <= {sh_q[6:0], 1'b0};
                cnt_q  <= cnt_q + 4'h1;
              end
            end
          end
          PM_TACK: begin
            if (scl_rise && sda_s[1]) begin
              state_q <= PM_IDLE;
            end else if (scl_fall) begin
              state_q <= PM_TX;
              sda_oe  <= ~rd_byte[7];
              sh_q    <= {rd_byte[6:0], 1'b0};
              cnt_q   <= 4'h1;
              if (rd_idx != 3'h7) begin
                rd_idx <= rd_idx + 3'h1;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// *** hdl/rlstc_regs.svh ***
/*
  Command codes, field positions, masks and reset values of the
  regulator loop, sequencing and tracking configuration block.
  Assumes it is included by its bare name; guarded against reuse.
*/
`ifndef RLSTC_REGS_SVH
`define RLSTC_REGS_SVH

`define RLSTC_CMD_DT_VALUE   8'hdd
`define RLSTC_CMD_GAP        8'hde
`define RLSTC_CMD_LOOP       8'hdf
`define RLSTC_CMD_ORDER      8'he0
`define RLSTC_CMD_FOLLOW     8'he1

`define RLSTC_GAP_MASK       16'hffff
`define RLSTC_LOOP_MASK      32'h01ffffff
`define RLSTC_ORDER_MASK     16'h9f9f
`define RLSTC_FOLLOW_MASK    8'h86

`define RLSTC_DT_VALUE_RST   16'h0000
`define RLSTC_GAP_RST        16'h0000
`define RLSTC_LOOP_RST       32'h00000000
`define RLSTC_ORDER_RST      16'h0000
`define RLSTC_FOLLOW_RST     8'h00

`define RLSTC_GAP_HL_MODE    15
`define RLSTC_GAP_HL_MIN     14:8
`define RLSTC_GAP_LH_MODE    7
`define RLSTC_GAP_LH_MIN     6:0
`define RLSTC_DT_HL          15:8
`define RLSTC_DT_LH          7:0
`define RLSTC_LOOP_BOOST     24
`define RLSTC_LOOP_RESID     23:16
`define RLSTC_LOOP_GAIN      15:0
`define RLSTC_ORD_PRE_EN     15
`define RLSTC_ORD_PRE_ID     12:8
`define RLSTC_ORD_SEQ_EN     7
`define RLSTC_ORD_SEQ_ID     4:0
`define RLSTC_FOL_EN         7
`define RLSTC_FOL_HALF       2
`define RLSTC_FOL_LIMIT      1

`define RLSTC_DT_MAX_RST     8'sh3c
`define RLSTC_DT_MIN_LO      7'sh7b
`define RLSTC_DT_MIN_HI      7'sh1c

`define RLSTC_LEN_BYTE       3'h1
`define RLSTC_LEN_WORD       3'h2
`define RLSTC_LEN_BLOCK      3'h5
`define RLSTC_BLOCK_COUNT    8'h04
`define RLSTC_BIT_LAST       4'h8

`endif

// *** hdl/rlstc_top.sv ***
/*
  Dead-time, loop response, rail ordering and voltage follow
  configuration behind a PMBus target, with the rail sequencer.
  Assumes group bus events and the enable request are on this clock.
*/
`timescale 1ns/100ps
`include "rlstc_regs.svh"

module rlstc_top
  import rlstc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40
)(
  input  wire logic              clock,          // 125 MHz clock
  input  wire logic              rst,            // Async reset, high
  input  wire logic              pm_scl_i,       // PMBus clock pin
  input  wire logic              pm_sda_i,       // PMBus data pin level
  output logic                   pm_sda_o,       // Data drive level
  output logic                   pm_sda_oe,      // Data pulled low
  input  wire logic              enable_req,     // Pin or command on
  input  wire logic              gcb_evt_valid,  // Group bus event
  input  wire logic              gcb_evt_pg,     // 1 good, 0 down
  input  wire logic        [4:0] gcb_evt_id,     // Sender rail id
  input  wire logic       [15:0] off_delay_cyc,  // Turn-off delay
  input  wire logic signed [7:0] dt_adapt_hl,    // Adaptive H-L ns
  input  wire logic signed [7:0] dt_adapt_lh,    // Adaptive L-H ns
  output logic                   rail_on,        // Output enabled
  output logic signed      [7:0] dt_hl_ns,       // H-L dead time ns
  output logic signed      [7:0] dt_lh_ns,       // L-H dead time ns
  output logic                   loop_response_boost_en, // Boost on
  output logic            [15:0] loop_gain,      // Gain factor
  output logic             [7:0] loop_residual,  // Residual factor
  output logic                   follow_en,      // Tracking on
  output logic                   follow_half,    // 50% of pin
  output logic                   follow_limit_pin // Cap at pin
);

  logic        wr_stb;
  logic  [7:0] wr_data;
  logic  [2:0] wr_idx;
  logic  [2:0] rd_idx;
  logic        stop_stb;
  logic  [7:0] rd_byte;
  logic  [7:0] cmd_q;
  logic  [2:0] nbytes_q;
  logic  [7:0] wbuf_q [0:4];
  logic [15:0] dt_value_q;
  logic [15:0] gap_q;
  logic [31:0] loop_q;
  logic [15:0] order_q;
  logic  [7:0] follow_q;
  logic        prev_dd_q;
  logic        commit;
  logic        max_load;
  logic [15:0] wword;
  logic [31:0] wblock;
  logic        pre_pg_q;
  logic        seq_dn_q;
  logic        pre_en;
  logic        seq_en;
  logic        pre_ready;
  logic        off_trig;
  logic        pre_match;
  logic        seq_match;
  logic [15:0] dly_q;
  rlstc_seq_e  state_q;
  logic  [1:0] chan_fixed;
  logic  [6:0] chan_min   [0:1];
  logic  [7:0] chan_val   [0:1];
  logic  [7:0] chan_adapt [0:1];
  logic  [7:0] chan_out   [0:1];

  rlstc_pmbus_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_pmbus (
    .clock    (clock),
    .rst      (rst),
    .scl_i    (pm_scl_i),
    .sda_i    (pm_sda_i),
    .sda_oe   (pm_sda_oe),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .wr_idx   (wr_idx),
    .rd_idx   (rd_idx),
    .stop_stb (stop_stb),
    .rd_byte  (rd_byte)
  );

  // Open-drain pin: only ever pulled low
  assign pm_sda_o = 1'b0;

  // Command byte and write data collection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_q    <= 8'h00;
      nbytes_q <= 3'h0;
      for (int i = 0; i < 5; i++) begin
        wbuf_q[i] <= 8'h00;
      end
    end else if (wr_stb) begin
      if (wr_idx == 3'h0) begin
        cmd_q    <= wr_data;
        nbytes_q <= 3'h0;
      end else begin
        nbytes_q <= wr_idx;
        if (wr_idx <= `RLSTC_LEN_BLOCK) begin
          wbuf_q[wr_idx - 3'h1] <= wr_data;
        end
      end
    end else if (stop_stb) begin
      // A later stop must not apply this write again
      nbytes_q <= 3'h0;
    end
  end

  assign wword  = {wbuf_q[1], wbuf_q[0]};
  assign wblock = {wbuf_q[4], wbuf_q[3], wbuf_q[2], wbuf_q[1]};

  always_comb begin
    commit = 1'b0;
    if (stop_stb) begin
      unique case (cmd_q)
        `RLSTC_CMD_DT_VALUE, `RLSTC_CMD_GAP, `RLSTC_CMD_ORDER:
          commit = nbytes_q == `RLSTC_LEN_WORD;
        `RLSTC_CMD_LOOP:
          commit = nbytes_q == `RLSTC_LEN_BLOCK &&
                   wbuf_q[0] == `RLSTC_BLOCK_COUNT;
        `RLSTC_CMD_FOLLOW:
          commit = nbytes_q == `RLSTC_LEN_BYTE;
        default:
          commit = 1'b0;
      endcase
    end
  end

  assign max_load = commit && cmd_q == `RLSTC_CMD_GAP && prev_dd_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dt_value_q <= `RLSTC_DT_VALUE_RST;
      gap_q      <= `RLSTC_GAP_RST;
      loop_q     <= `RLSTC_LOOP_RST;
      order_q    <= `RLSTC_ORDER_RST;
      follow_q   <= `RLSTC_FOLLOW_RST;
      prev_dd_q  <= 1'b0;
    end else if (commit) begin
      prev_dd_q <= cmd_q == `RLSTC_CMD_DT_VALUE;
      unique case (cmd_q)
        `RLSTC_CMD_DT_VALUE: dt_value_q <= wword;
        `RLSTC_CMD_GAP:      gap_q      <= wword & `RLSTC_GAP_MASK;
        `RLSTC_CMD_LOOP:     loop_q     <= wblock & `RLSTC_LOOP_MASK;
        `RLSTC_CMD_ORDER:    order_q    <= wword & `RLSTC_ORDER_MASK;
        `RLSTC_CMD_FOLLOW:   follow_q   <= wbuf_q[0] & `RLSTC_FOLLOW_MASK;
        default:             prev_dd_q  <= 1'b0;
      endcase
    end
  end

  // Read data, least significant byte first; block opens with count
  always_comb begin
    rd_byte = 8'h00;
    unique case (cmd_q)
      `RLSTC_CMD_DT_VALUE:
        rd_byte = rd_idx[0] ? dt_value_q[15:8] : dt_value_q[7:0];
      `RLSTC_CMD_GAP:
        rd_byte = rd_idx[0] ? gap_q[15:8] : gap_q[7:0];
      `RLSTC_CMD_ORDER:
        rd_byte = rd_idx[0] ? order_q[15:8] : order_q[7:0];
      `RLSTC_CMD_FOLLOW:
        rd_byte = follow_q;
      `RLSTC_CMD_LOOP: begin
        unique case (rd_idx)
          3'h0:    rd_byte = `RLSTC_BLOCK_COUNT;
          3'h1:    rd_byte = loop_q[7:0];
          3'h2:    rd_byte = loop_q[15:8];
          3'h3:    rd_byte = loop_q[23:16];
          3'h4:    rd_byte = loop_q[31:24];
          default: rd_byte = 8'h00;
        endcase
      end
      default:
        rd_byte = 8'h00;
    endcase
  end

  // Dead-time channels: index 0 is H-L, index 1 is L-H
  assign chan_fixed    = {gap_q[`RLSTC_GAP_LH_MODE],
                          gap_q[`RLSTC_GAP_HL_MODE]};
  assign chan_min[0]   = gap_q[`RLSTC_GAP_HL_MIN];
  assign chan_min[1]   = gap_q[`RLSTC_GAP_LH_MIN];
  assign chan_val[0]   = dt_value_q[`RLSTC_DT_HL];
  assign chan_val[1]   = dt_value_q[`RLSTC_DT_LH];
  assign chan_adapt[0] = dt_adapt_hl;
  assign chan_adapt[1] = dt_adapt_lh;
  assign dt_hl_ns      = chan_out[0];
  assign dt_lh_ns      = chan_out[1];

  for (genvar g = 0; g < 2; g++) begin : g_chan
    rlstc_dt_chan u_chan (
      .clock      (clock),
      .rst        (rst),
      .fixed_mode (chan_fixed[g]),
      .min_code   (chan_min[g]),
      .fixed_ns   (chan_val[g]),
      .max_load   (max_load),
      .adapt_ns   (chan_adapt[g]),
      .dt_ns_q    (chan_out[g])
    );
  end

  assign loop_response_boost_en = loop_q[`RLSTC_LOOP_BOOST];
  assign loop_gain              = loop_q[`RLSTC_LOOP_GAIN];
  assign loop_residual          = loop_q[`RLSTC_LOOP_RESID];
  assign follow_en              = follow_q[`RLSTC_FOL_EN];
  assign follow_half            = follow_q[`RLSTC_FOL_HALF];
  assign follow_limit_pin       = follow_q[`RLSTC_FOL_LIMIT];

  // Rail sequencing on group bus events
  assign pre_en    = order_q[`RLSTC_ORD_PRE_EN];
  assign seq_en    = order_q[`RLSTC_ORD_SEQ_EN];
  assign pre_match = gcb_evt_valid &&
                     gcb_evt_id == order_q[`RLSTC_ORD_PRE_ID];
  assign seq_match = gcb_evt_valid &&
                     gcb_evt_id == order_q[`RLSTC_ORD_SEQ_ID];
  assign pre_ready = !pre_en || pre_pg_q;
  assign off_trig  = seq_en ? seq_dn_q : !enable_req;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_pg_q <= 1'b0;
    end else if (pre_match) begin
      pre_pg_q <= gcb_evt_pg;
    end
  end

  // A matching event in the clearing cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_dn_q <= 1'b0;
    end else if (seq_match) begin
      seq_dn_q <= !gcb_evt_pg;
    end else if (state_q == SEQ_OFF) begin
      seq_dn_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SEQ_OFF;
      dly_q   <= 16'h0000;
      rail_on <= 1'b0;
    end else begin
      unique case (state_q)
        SEQ_OFF, SEQ_WAIT_PRE: begin
          if (!enable_req) begin
            state_q <= SEQ_OFF;
          end else if (pre_ready) begin
            state_q <= SEQ_ON;
            rail_on <= 1'b1;
          end else begin
            state_q <= SEQ_WAIT_PRE;
          end
        end
        SEQ_ON: begin
          if (off_trig) begin
            state_q <= SEQ_OFF_DLY;
            dly_q   <= off_delay_cyc;
          end
        end
        SEQ_OFF_DLY: begin
          if (dly_q == 16'h0000) begin
            state_q <= SEQ_OFF;
            rail_on <= 1'b0;
          end else begin
            dly_q <= dly_q - 16'h0001;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  rail_on_gate_a: assert property (
    $rose(rail_on) |-> $past(enable_req) && $past(pre_ready))
    else $error("Rail came on without enable and prequel good");
  no_prequel_wait_a: assert property (
    state_q == SEQ_OFF && enable_req && !pre_en |=> rail_on)
    else $error("Rail waited with prequel disabled");
  sequel_shutdown_a: assert property (
    state_q == SEQ_ON && seq_en && seq_dn_q |=> state_q == SEQ_OFF_DLY
    ##1 (state_q == SEQ_OFF_DLY && rail_on))
    else $error("Sequel power-down not followed by delayed turn-off");
  off_delay_end_a: assert property (
    state_q == SEQ_OFF_DLY && dly_q == 16'h0000 |=> !rail_on)
    else $error("Rail stayed on after turn-off delay");
  foreign_id_a: assert property (
    gcb_evt_valid && gcb_evt_pg && !pre_pg_q && !commit &&
    gcb_evt_id != order_q[`RLSTC_ORD_PRE_ID] |=> !pre_pg_q)
    else $error("Power-good from another rail accepted");
  order_write_a: assert property (
    commit && cmd_q == `RLSTC_CMD_ORDER |=>
    order_q == ($past(wword) & `RLSTC_ORDER_MASK))
    else $error("Rail ordering write not stored");
  follow_mask_a: assert property (
    commit && cmd_q == `RLSTC_CMD_FOLLOW |=>
    (follow_q & ~`RLSTC_FOLLOW_MASK) == 8'h00 &&
    follow_en == $past(wbuf_q[0][`RLSTC_FOL_EN]))
    else $error("Follow settings write mishandled");
  frozen_value_a: assert property (
    gap_q[`RLSTC_GAP_HL_MODE] |=>
    dt_hl_ns == $past(dt_value_q[`RLSTC_DT_HL]))
    else $error("Frozen H-L dead time not the stored value");
  max_pair_a: assert property (
    commit && cmd_q == `RLSTC_CMD_GAP |=> !prev_dd_q)
    else $error("Value-then-mode pairing not consumed");

  on_after_prequel_c: cover property (
    state_q == SEQ_WAIT_PRE ##[1:100] rail_on);
  sequel_off_c: cover property (
    seq_en && $rose(seq_dn_q) ##[1:100] !rail_on);
  block_write_c: cover property (commit && cmd_q == `RLSTC_CMD_LOOP);
  max_load_c: cover property (max_load);

endmodule
